// File: inc/tlbm_pkg.sv
// Purpose: Constants and carrier types for the translation buffer block
// Assumes: 32-bit addressing mode, 32-entry buffer
// Notes:   Register numbers are those used by the privileged move port

package tlbm_pkg;

    // ****************************************************************
    // Sizes and register numbers
    // ****************************************************************
    localparam int         TLBM_ENTRIES      = 32;
    localparam int         TLBM_IDX_W        = 5;
    localparam logic [4:0] TLBM_REG_INDEX    = 5'h00;
    localparam logic [4:0] TLBM_REG_RAND     = 5'h01;
    localparam logic [4:0] TLBM_REG_LO0      = 5'h02;
    localparam logic [4:0] TLBM_REG_LO1      = 5'h03;
    localparam logic [4:0] TLBM_REG_MASK     = 5'h05;
    localparam logic [4:0] TLBM_REG_WIRED    = 5'h06;

    // ****************************************************************
    // Reset values, field positions, encodings
    // ****************************************************************
    localparam logic [4:0] TLBM_RAND_TOP     = 5'h1f;
    localparam logic [4:0] TLBM_WIRED_RST    = 5'h00;
    localparam int         TLBM_PROBE_BIT    = 31;
    localparam int         TLBM_MASK_LSB     = 11;
    localparam int         TLBM_MASK_MSB     = 18;
    localparam int         TLBM_LO_MSB       = 27;
    localparam int         TLBM_VIRTUAL_PAGE_PAIR_NUMBER_LSB     = 11;
    localparam int         TLBM_PAGE_LSB     = 10;
    localparam logic [2:0] TLBM_C_UNCACHED   = 3'h2;
    localparam logic [7:0] TLBM_MASK_1K      = 8'h00;
    localparam logic [7:0] TLBM_MASK_4K      = 8'h03;
    localparam logic [7:0] TLBM_MASK_16K     = 8'h0f;
    localparam logic [7:0] TLBM_MASK_64K     = 8'h3f;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    // Page low word as held in the register (bits 27:0)
    typedef struct packed {
        logic [21:0] page_frame_number;
        logic [2:0]  c;
        logic        d;
        logic        v;
        logic        g;
    } tlbm_lo_s;

    // One buffer entry; global lives in both lo.g copies
    typedef struct packed {
        logic [7:0]  mask;
        logic [20:0] virtual_page_pair_number;
        logic [7:0]  address_space_tag;
        tlbm_lo_s    lo0;
        tlbm_lo_s    lo1;
    } tlbm_entry_s;

    // Translation answer
    typedef struct packed {
        logic        done;
        logic        miss;
        logic        uncached;
        logic        inv_load;
        logic        inv_store;
        logic        wprot;
        logic [31:0] paddr;
    } tlbm_xl_s;

endpackage : tlbm_pkg

// File: rtl/tlbm_top.sv
// Purpose: Translation buffer and its management registers
// Assumes: Instruction strobes are one-cycle pulses, one at a time
// Notes:   All effects land at the clock edge after the strobe

`timescale 1ns/1ns

module tlbm_top
    import tlbm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CE,
    // Register move port
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    input  wire logic [4:0]  I_REG_NUM,
    input  wire logic [31:0] I_REG_WDATA,
    output logic      [31:0] O_REG_RDATA,
    // Instruction strobes
    input  wire logic        I_INSN_RETIRE,
    input  wire logic        I_PROBE,
    input  wire logic        I_IDX_READ,
    input  wire logic        I_IDX_WRITE,
    input  wire logic        I_RAND_WRITE,
    // High word held outside
    input  wire logic [20:0] I_HI_VIRTUAL_PAGE_PAIR_NUMBER,
    input  wire logic [7:0]  I_HI_ADDRESS_SPACE_TAG,
    output logic      [20:0] O_RD_VIRTUAL_PAGE_PAIR_NUMBER,
    output logic      [7:0]  O_RD_ADDRESS_SPACE_TAG,
    // Translation request and answer
    input  wire logic        I_XL_REQ,
    input  wire logic        I_XL_STORE,
    input  wire logic [31:0] I_XL_VADDR,
    input  wire logic [7:0]  I_XL_ADDRESS_SPACE_TAG,
    output tlbm_xl_s         O_XL
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic                  rst_meta;
    logic                  rst_n;
    tlbm_entry_s           ent [TLBM_ENTRIES];
    logic [TLBM_IDX_W-1:0] index;
    logic                  probe_fail;
    logic [TLBM_IDX_W-1:0] rand_idx;
    logic [TLBM_IDX_W-1:0] wired;
    tlbm_lo_s              lo0;
    tlbm_lo_s              lo1;
    logic [7:0]            pmask;
    logic [31:0]           xl_match;
    logic [31:0]           pr_match;
    logic [TLBM_IDX_W-1:0] xl_idx;
    logic [TLBM_IDX_W-1:0] pr_idx;
    logic                  wr_any;
    logic [TLBM_IDX_W-1:0] wr_idx;
    logic                  wired_wr;

    // Compare one entry against a page-pair and tag
    function automatic logic hit(tlbm_entry_s e, logic [20:0] virtual_page_pair_number,
                                 logic [7:0] address_space_tag);
        logic [20:0] keep;
        keep = {13'h1fff, ~e.mask};
        hit  = (((virtual_page_pair_number ^ e.virtual_page_pair_number) & keep) == 21'h000000)
               && (e.lo0.g || (e.address_space_tag == address_space_tag));
    endfunction : hit

    // Lowest matching entry number
    function automatic logic [4:0] first(logic [31:0] vec);
        first = 5'h00;
        for (int i = TLBM_ENTRIES - 1; i >= 0; i--) begin
            if (vec[i]) begin
                first = 5'(i);
            end
        end
    endfunction : first

    // Reset release through two flops
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************************
    // Parallel compare of all entries
    // ****************************************************************
    // One comparator pair per entry
    generate
        for (genvar e = 0; e < TLBM_ENTRIES; e++) begin : g_cmp
            assign xl_match[e] = hit(ent[e], I_XL_VADDR[31:TLBM_VIRTUAL_PAGE_PAIR_NUMBER_LSB],
                                     I_XL_ADDRESS_SPACE_TAG);
            assign pr_match[e] = hit(ent[e], I_HI_VIRTUAL_PAGE_PAIR_NUMBER, I_HI_ADDRESS_SPACE_TAG);
        end
    endgenerate

    // Hit encoders and write target selection
    assign xl_idx   = first(xl_match);
    assign pr_idx   = first(pr_match);
    assign wr_any   = I_IDX_WRITE | I_RAND_WRITE;
    assign wr_idx   = I_RAND_WRITE ? rand_idx : index;
    assign wired_wr = I_REG_WR && (I_REG_NUM == TLBM_REG_WIRED);

    // ****************************************************************
    // Buffer entries
    // ****************************************************************
    // Entry write from staging registers and high-word inputs; replacement index never
    // goes below the boundary, so random writes leave locked entries untouched
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < TLBM_ENTRIES; i++) begin
                ent[i] <= '0;
            end
        end else if (I_CE && wr_any) begin
            ent[wr_idx].mask     <= pmask;
            ent[wr_idx].virtual_page_pair_number     <= I_HI_VIRTUAL_PAGE_PAIR_NUMBER;
            ent[wr_idx].address_space_tag     <= I_HI_ADDRESS_SPACE_TAG;
            ent[wr_idx].lo0      <= lo0;
            ent[wr_idx].lo1      <= lo1;
            ent[wr_idx].lo0.g    <= lo0.g & lo1.g;
            ent[wr_idx].lo1.g    <= lo0.g & lo1.g;
        end
    end

    // ****************************************************************
    // Index register and probe
    // ****************************************************************
    // Probe takes priority over a software move in the same cycle
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            index      <= 5'h00;
            probe_fail <= 1'b0;
        end else if (I_CE) begin
            if (I_PROBE) begin
                probe_fail <= ~|pr_match;
                if (|pr_match) begin
                    index <= pr_idx;
                end
            end else if (I_REG_WR && (I_REG_NUM == TLBM_REG_INDEX)) begin
                index <= I_REG_WDATA[TLBM_IDX_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Replacement index and boundary
    // ****************************************************************
    // Boundary write wins over the per-instruction step
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rand_idx <= TLBM_RAND_TOP;
        end else if (I_CE) begin
            if (wired_wr) begin
                rand_idx <= TLBM_RAND_TOP;
            end else if (I_INSN_RETIRE) begin
                if (rand_idx <= wired) begin
                    rand_idx <= TLBM_RAND_TOP;
                end else begin
                    rand_idx <= rand_idx - 5'h01;
                end
            end
        end
    end

    // Locked-entry boundary
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            wired <= TLBM_WIRED_RST;
        end else if (I_CE && wired_wr) begin
            wired <= I_REG_WDATA[TLBM_IDX_W-1:0];
        end
    end

    // ****************************************************************
    // Staging registers
    // ****************************************************************
    // Indexed read overrides software moves
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            lo0       <= '0;
            lo1       <= '0;
            pmask     <= 8'h00;
            O_RD_VIRTUAL_PAGE_PAIR_NUMBER <= 21'h000000;
            O_RD_ADDRESS_SPACE_TAG <= 8'h00;
        end else if (I_CE) begin
            if (I_IDX_READ) begin
                lo0       <= ent[index].lo0;
                lo1       <= ent[index].lo1;
                pmask     <= ent[index].mask;
                O_RD_VIRTUAL_PAGE_PAIR_NUMBER <= ent[index].virtual_page_pair_number;
                O_RD_ADDRESS_SPACE_TAG <= ent[index].address_space_tag;
            end else if (I_REG_WR) begin
                case (I_REG_NUM)
                    TLBM_REG_LO0:  lo0   <= I_REG_WDATA[TLBM_LO_MSB:0];
                    TLBM_REG_LO1:  lo1   <= I_REG_WDATA[TLBM_LO_MSB:0];
                    TLBM_REG_MASK: begin
                        pmask <= I_REG_WDATA[TLBM_MASK_MSB:TLBM_MASK_LSB];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    // Registered read; reserved and unmapped bits return zero
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_REG_RDATA <= 32'h00000000;
        end else if (I_CE && I_REG_RD) begin
            O_REG_RDATA <= 32'h00000000;
            case (I_REG_NUM)
                TLBM_REG_INDEX: begin
                    O_REG_RDATA[TLBM_PROBE_BIT]    <= probe_fail;
                    O_REG_RDATA[TLBM_IDX_W-1:0]    <= index;
                end
                TLBM_REG_RAND:  O_REG_RDATA[4:0] <= rand_idx;
                TLBM_REG_LO0:   O_REG_RDATA[TLBM_LO_MSB:0] <= lo0;
                TLBM_REG_LO1:   O_REG_RDATA[TLBM_LO_MSB:0] <= lo1;
                TLBM_REG_MASK: begin
                    O_REG_RDATA[TLBM_MASK_MSB:TLBM_MASK_LSB] <= pmask;
                end
                TLBM_REG_WIRED: O_REG_RDATA[4:0] <= wired;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Address translation
    // ****************************************************************
    tlbm_entry_s xe;
    tlbm_lo_s    xp;
    logic        odd;
    logic [7:0]  xpa;

    assign xe = ent[xl_idx];

    // Page select bit sits just above the page offset
    always_comb begin
        case (xe.mask)
            TLBM_MASK_1K:  odd = I_XL_VADDR[10];
            TLBM_MASK_4K:  odd = I_XL_VADDR[12];
            TLBM_MASK_16K: odd = I_XL_VADDR[14];
            TLBM_MASK_64K: odd = I_XL_VADDR[16];
            default:       odd = I_XL_VADDR[18];
        endcase
    end

    assign xp = odd ? xe.lo1 : xe.lo0;

    // Offset bits widen with the mask
    generate
        for (genvar j = 0; j < 8; j++) begin : g_pa
            assign xpa[j] = xe.mask[j] ? I_XL_VADDR[TLBM_PAGE_LSB + j]
                                       : xp.page_frame_number[j];
        end
    endgenerate

    // Registered translation answer; changes are seen next cycle
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_XL <= '0;
        end else if (I_CE) begin
            O_XL.done      <= I_XL_REQ;
            O_XL.miss      <= I_XL_REQ & ~|xl_match;
            O_XL.uncached  <= xp.c == TLBM_C_UNCACHED;
            O_XL.inv_load  <= I_XL_REQ & |xl_match & ~xp.v
                              & ~I_XL_STORE;
            O_XL.inv_store <= I_XL_REQ & |xl_match & ~xp.v & I_XL_STORE;
            O_XL.wprot     <= I_XL_REQ & |xl_match & xp.v
                              & ~xp.d & I_XL_STORE;
            O_XL.paddr     <= {xp.page_frame_number[21:8], xpa, I_XL_VADDR[9:0]};
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_step;
        I_CE && I_INSN_RETIRE && !wired_wr;
    endsequence

    property p_rand_range;
        rand_idx >= wired;
    endproperty
    a_rand_range: assert property (p_rand_range)
        else $error("replacement index below boundary");

    property p_rand_dec;
        s_step ##0 (rand_idx > wired) |=>
            rand_idx == $past(rand_idx) - 5'h01;
    endproperty
    a_rand_dec: assert property (p_rand_dec)
        else $error("replacement index did not decrement");

    property p_rand_wrap;
        s_step ##0 (rand_idx == wired) |=> rand_idx == TLBM_RAND_TOP;
    endproperty
    a_rand_wrap: assert property (p_rand_wrap)
        else $error("replacement index did not wrap to top");

    property p_wired_load;
        I_CE && wired_wr |=> rand_idx == TLBM_RAND_TOP
            && wired == $past(I_REG_WDATA[4:0]);
    endproperty
    a_wired_load: assert property (p_wired_load)
        else $error("boundary write did not reload index");

    property p_probe_miss;
        I_CE && I_PROBE && pr_match == 32'h0 |=> probe_fail;
    endproperty
    a_probe_miss: assert property (p_probe_miss)
        else $error("probe miss did not set failure bit");

    property p_probe_hit;
        I_CE && I_PROBE && pr_match != 32'h0 |=>
            !probe_fail && index == $past(pr_idx);
    endproperty
    a_probe_hit: assert property (p_probe_hit)
        else $error("probe hit index wrong");

    sequence s_rd_index;
        I_CE && I_REG_RD && I_REG_NUM == TLBM_REG_INDEX;
    endsequence

    property p_resv_zero;
        s_rd_index |=> O_REG_RDATA[30:5] == 26'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved index bits not zero");

    property p_inv_load;
        I_CE && I_XL_REQ && xl_match != 32'h0 && !xp.v && !I_XL_STORE
            |=> O_XL.inv_load && !O_XL.inv_store;
    endproperty
    a_inv_load: assert property (p_inv_load)
        else $error("invalid load not flagged");

    property p_uncached;
        I_CE && I_XL_REQ |=> O_XL.uncached == ($past(xp.c) == 3'h2);
    endproperty
    a_uncached: assert property (p_uncached)
        else $error("uncached attribute wrong");

endmodule : tlbm_top

// File: sim/tlbm_core_model.sv
// Purpose: Core pipeline model driving the buffer's move port
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   The bench calls these tasks; each request ends with an idle edge

`timescale 1ns/1ns

module tlbm_core_model
    import tlbm_pkg::*;
(
    // Clock
    input  wire logic        i_clk,
    // Move port
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic      [4:0]  o_reg_num,
    output logic      [31:0] o_reg_wdata,
    input  wire logic [31:0] i_reg_rdata,
    // Strobes: probe, indexed read, indexed write, random write
    output logic      [3:0]  o_insn,
    output logic             o_retire,
    // Lookup
    output logic             o_xl_req,
    output logic             o_xl_store,
    output logic      [31:0] o_xl_vaddr,
    input  tlbm_xl_s         i_xl
);

    // ****************************************************************
    // Idle levels at time zero
    // ****************************************************************
    initial begin
        {o_reg_wr, o_reg_rd, o_retire, o_xl_req, o_xl_store} = 5'h00;
        o_reg_num   = 5'h00;
        o_reg_wdata = 32'h0;
        o_insn      = 4'h0;
        o_xl_vaddr  = 32'h0;
    end

    // One move held for one taking edge; read data lands at that edge.
    // An idle edge follows so a next move never re-raises a strobe in
    // the same time step
    task automatic reg_op(input logic w, input logic [4:0] n,
                          input logic [31:0] d, output logic [31:0] q);
        o_reg_wr    = w;
        o_reg_rd    = ~w;
        o_reg_num   = n;
        o_reg_wdata = d;
        @(posedge i_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        q        = i_reg_rdata;
        @(posedge i_clk);
        #1;
    endtask : reg_op

    // Register write
    task automatic reg_wr(input logic [4:0] n, input logic [31:0] d);
        logic [31:0] q;
        reg_op(1'b1, n, d, q);
    endtask : reg_wr

    // Register read
    task automatic reg_rd(input logic [4:0] n, output logic [31:0] d);
        reg_op(1'b0, n, 32'h0, d);
    endtask : reg_rd

    // One instruction strobe, one cycle wide, then one idle edge
    task automatic insn(input int k);
        o_insn = 4'h1 << k;
        @(posedge i_clk);
        #1;
        o_insn = 4'h0;
        @(posedge i_clk);
        #1;
    endtask : insn

    // Retire one instruction on each of n edges, then one idle edge
    task automatic run(input int n);
        o_retire = (n > 0);
        repeat (n) @(posedge i_clk);
        #1;
        o_retire = 1'b0;
        @(posedge i_clk);
        #1;
    endtask : run

    // Lookup; the answer stands for the cycle after the taking edge
    task automatic xl(input logic st, input logic [31:0] va,
                      output tlbm_xl_s r);
        o_xl_req   = 1'b1;
        o_xl_store = st;
        o_xl_vaddr = va;
        @(posedge i_clk);
        #1;
        o_xl_req = 1'b0;
        r        = i_xl;
        @(posedge i_clk);
        #1;
    endtask : xl

endmodule : tlbm_core_model

// File: sim/tlbm_top_bench.sv
// Purpose: Self-checking bench for the translation buffer block
// Assumes: Move port answers at the taking edge
// Notes:   Inputs change 1 ns after the rising edge

`timescale 1ns/1ns

module tlbm_top_bench
    import tlbm_pkg::*;
;

    // ****************************************************************
    // Clock, reset and wiring
    // ****************************************************************
    localparam logic [37:0] ALL = '1;
    localparam logic [37:0] FLG = {6'h3f, 32'h0};
    localparam logic [37:0] DM  = {2'h3, 36'h0};
    // Listed page-size patterns plus the all-ones mask 8'hff
    localparam logic [7:0]  MK [5] = '{TLBM_MASK_1K, TLBM_MASK_4K,
        TLBM_MASK_16K, TLBM_MASK_64K, 8'hff};
    logic        clk     = 1'b0;
    logic        rst_n   = 1'b0;
    logic        ce;
    logic [20:0] hi_virtual_page_pair_number = 21'h0;
    logic [7:0]  hi_address_space_tag;
    logic [7:0]  xl_address_space_tag;
    logic        reg_wr, reg_rd, retire, xl_req, xl_store;
    logic [4:0]  reg_num;
    logic [31:0] wdata, rdata, vaddr;
    logic [3:0]  insn;
    logic [20:0] rd_virtual_page_pair_number;
    logic [7:0]  rd_address_space_tag;
    tlbm_xl_s    xl;
    int          errors    = 0;
    int          cmp_count = 0;

    // Free-running clock
    always #20 clk = ~clk;

    tlbm_top i_tlbm_top (
        .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .I_REG_NUM(reg_num),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .I_INSN_RETIRE(retire), .I_PROBE(insn[0]),
        .I_IDX_READ(insn[1]), .I_IDX_WRITE(insn[2]),
        .I_RAND_WRITE(insn[3]), .I_HI_VIRTUAL_PAGE_PAIR_NUMBER(hi_virtual_page_pair_number),
        .I_HI_ADDRESS_SPACE_TAG(hi_address_space_tag), .O_RD_VIRTUAL_PAGE_PAIR_NUMBER(rd_virtual_page_pair_number), .O_RD_ADDRESS_SPACE_TAG(rd_address_space_tag),
        .I_XL_REQ(xl_req), .I_XL_STORE(xl_store), .I_XL_VADDR(vaddr),
        .I_XL_ADDRESS_SPACE_TAG(xl_address_space_tag), .O_XL(xl)
    );

    tlbm_core_model i_tlbm_core_model (
        .i_clk(clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_num(reg_num), .o_reg_wdata(wdata), .i_reg_rdata(rdata),
        .o_insn(insn), .o_retire(retire), .o_xl_req(xl_req),
        .o_xl_store(xl_store), .o_xl_vaddr(vaddr), .i_xl(xl)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string w, input logic [37:0] e,
                       input logic [37:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    // Enable level and the two address space tags
    task automatic drive(input logic e, input logic [7:0] h,
                         input logic [7:0] x);
        ce      = e;
        hi_address_space_tag = h;
        xl_address_space_tag = x;
    endtask : drive

    task automatic wr(input logic [4:0] n, input logic [31:0] d);
        i_tlbm_core_model.reg_wr(n, d);
    endtask : wr

    task automatic rdc(input logic [4:0] n, input logic [31:0] e,
                       input string w);
        logic [31:0] d;
        i_tlbm_core_model.reg_rd(n, d);
        chk(w, {6'h0, e}, {6'h0, d});
    endtask : rdc

    function automatic logic [31:0] lo(input logic [21:0] p,
        input logic [2:0] c, input logic d, input logic v, input logic g);
        return {4'h0, p, c, d, v, g};
    endfunction : lo

    // Stage an entry and write it by index
    task automatic put(input logic [4:0] i, input logic [31:0] l0,
        input logic [31:0] l1, input logic [7:0] m, input logic [20:0] vp);
        hi_virtual_page_pair_number = vp;
        wr(TLBM_REG_LO0, l0);
        wr(TLBM_REG_LO1, l1);
        wr(TLBM_REG_MASK, {13'h0, m, 11'h0});
        wr(TLBM_REG_INDEX, {27'h0, i});
        i_tlbm_core_model.insn(2);
    endtask : put

    task automatic xlc(input logic st, input logic [31:0] va,
        input logic [37:0] e, input logic [37:0] cm, input string w);
        tlbm_xl_s r;
        i_tlbm_core_model.xl(st, va, r);
        chk(w, e & cm, r & cm);
    endtask : xlc

    task automatic conclude;
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int          sel;
        logic [31:0] off;
        logic [31:0] va;
        logic [37:0] ep;
        drive(1'b1, 8'h5a, 8'h5a);
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // Reset values, read-only and reserved bits
        rdc(TLBM_REG_INDEX, 32'h0, "index");
        rdc(TLBM_REG_RAND, 32'h1f, "replace");
        rdc(TLBM_REG_WIRED, 32'h0, "boundary");
        rdc(5'h04, 32'h0, "unmapped");
        wr(TLBM_REG_RAND, 32'h3);
        rdc(TLBM_REG_RAND, 32'h1f, "replace ro");
        wr(TLBM_REG_INDEX, 32'h00000015);
        rdc(TLBM_REG_INDEX, 32'h15, "index bits");
        wr(TLBM_REG_LO0, 32'h0fffffff);
        rdc(TLBM_REG_LO0, 32'h0fffffff, "lo0 bits");
        wr(TLBM_REG_MASK, 32'h0007f800);
        rdc(TLBM_REG_MASK, 32'h0007f800, "mask bits");
        // Replacement index walk, reload, freeze, floor, wrap
        i_tlbm_core_model.run(3);
        rdc(TLBM_REG_RAND, 32'h1c, "replace dec");
        wr(TLBM_REG_WIRED, 32'h8);
        rdc(TLBM_REG_RAND, 32'h1f, "replace reload");
        drive(1'b0, hi_address_space_tag, xl_address_space_tag);
        i_tlbm_core_model.run(5);
        drive(1'b1, hi_address_space_tag, xl_address_space_tag);
        rdc(TLBM_REG_RAND, 32'h1f, "replace frozen");
        i_tlbm_core_model.run(23);
        rdc(TLBM_REG_RAND, 32'h8, "replace floor");
        i_tlbm_core_model.run(1);
        rdc(TLBM_REG_RAND, 32'h1f, "replace wrap");
        // Locked entry written by index, read back
        put(5'd3, lo(22'h12345, 3'h2, 1'b0, 1'b1, 1'b1),
            lo(22'h2abcd, 3'h3, 1'b1, 1'b0, 1'b0), 8'h00, 21'h0a5a5);
        wr(TLBM_REG_LO0, 32'h0);
        wr(TLBM_REG_LO1, 32'h0);
        i_tlbm_core_model.insn(1);
        rdc(TLBM_REG_LO0, lo(22'h12345, 3'h2, 1'b0, 1'b1, 1'b0), "lo0");
        rdc(TLBM_REG_LO1, lo(22'h2abcd, 3'h3, 1'b1, 1'b0, 1'b0), "lo1");
        chk("virtual_page_pair_number", {17'h0, 21'h0a5a5}, {17'h0, rd_virtual_page_pair_number});
        chk("address_space_tag", 38'h5a, {30'h0, rd_address_space_tag});
        // Probe miss then hit
        hi_virtual_page_pair_number = 21'h0a5a4;
        i_tlbm_core_model.insn(0);
        rdc(TLBM_REG_INDEX, 32'h80000003, "probe miss");
        hi_virtual_page_pair_number = 21'h0a5a5;
        i_tlbm_core_model.insn(0);
        rdc(TLBM_REG_INDEX, 32'h3, "probe hit");
        // Lookups on even and odd pages
        xlc(1'b0, {21'h0a5a5, 11'h123},
            {6'b101000, 22'h12345, 10'h123}, ALL, "even ld");
        xlc(1'b1, {21'h0a5a5, 11'h123},
            {6'b101001, 22'h12345, 10'h123}, ALL, "even st");
        xlc(1'b0, {21'h0a5a5, 11'h4ab}, {6'b100100, 32'h0}, FLG, "odd ld");
        xlc(1'b1, {21'h0a5a5, 11'h4ab}, {6'b100010, 32'h0}, FLG, "odd st");
        drive(ce, 8'h77, 8'h11);
        xlc(1'b0, {21'h0a5a5, 11'h123}, {2'b11, 36'h0}, DM, "tag miss");
        put(5'd4, lo(22'h00777, 3'h0, 1'b1, 1'b1, 1'b1),
            lo(22'h00888, 3'h0, 1'b1, 1'b1, 1'b1), 8'h00, 21'h033333);
        xlc(1'b1, {21'h033333, 11'h055},
            {6'b100000, 22'h00777, 10'h055}, ALL, "global");
        // Every listed page size, odd page, masked bits set
        drive(ce, 8'h5a, 8'h5a);
        for (int k = 0; k < 5; k++) begin
            sel = 10 + 2 * k;
            off = 32'h0002a6c5 & ((32'h1 << sel) - 32'h1);
            put(5'd5, lo(22'h0c0de, 3'h1, 1'b1, 1'b1, 1'b0),
                lo(22'h3a1b2, 3'h7, 1'b1, 1'b1, 1'b0), MK[k], 21'h150000);
            va = {21'h150000, 11'h0} | (32'h1 << sel) | off;
            ep = {6'b100000, ({22'h3a1b2, 10'h0} & ~(off | (off - off)
                 | ((32'h1 << sel) - 32'h1))) | off};
            xlc(1'b0, va, ep, ALL, "page size");
        end
        // Random write lands on the replacement entry
        i_tlbm_core_model.run(2);
        rdc(TLBM_REG_RAND, 32'h1d, "replace");
        wr(TLBM_REG_LO0, lo(22'h3f00f, 3'h4, 1'b1, 1'b1, 1'b0));
        i_tlbm_core_model.insn(3);
        wr(TLBM_REG_INDEX, 32'h1d);
        wr(TLBM_REG_LO0, 32'h0);
        i_tlbm_core_model.insn(1);
        rdc(TLBM_REG_LO0, lo(22'h3f00f, 3'h4, 1'b1, 1'b1, 1'b0), "rand");
        conclude();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end

endmodule : tlbm_top_bench
